// file: core/mcu_parallel_port_unit.sv
// four-port parallel I/O unit with mode latch and external bus strobes
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mcu_parallel_port_unit #(
   parameter int ADDR_W = 12
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic reset_n,
   input wire logic [7:0] p1_in,
   output logic [7:0] p1_out,
   output logic [7:0] p1_oe,
   input wire logic [4:0] p2_in,
   output logic [4:0] p2_out,
   output logic [4:0] p2_oe,
   input wire logic [7:0] p3_in,
   output logic [7:0] p3_out,
   output logic [7:0] p3_oe,
   input wire logic [7:0] p4_in,
   output logic [7:0] p4_out,
   output logic [7:0] p4_oe,
   input wire logic sc1_in,
   output logic sc1_out,
   output logic sc1_oe,
   output logic sc2_out,
   output logic maskable_irq_a,
   output logic [2:0] mode,
   input wire logic bus_req,
   input wire logic [15:0] bus_addr,
   input wire logic bus_we,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   output logic bus_done
);
   localparam logic [1:0] ADDR_HIGH_AT =
      2'(mcu_port_pkg::RST_LOW_CYCLES - 1);

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   // port number from a register index: 0,2 -> 0; 1,3 -> 1; 4,6 -> 2...
   function automatic logic [1:0] port_of(input logic [3:0] idx);
      port_of = {idx[2], idx[0]};
   endfunction

   // pins for inputs, output latch for outputs
   function automatic logic [7:0] mix(input logic [7:0] pins,
         input logic [7:0] outv, input logic [7:0] dir);
      mix = (pins & ~dir) | (outv & dir);
   endfunction

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   logic [7:0] dir_reg [0:3];
   logic [7:0] out_reg [0:3];
   logic [2:0] mode_reg;
   logic rst_prev_reg;
   logic [1:0] rst_cnt_reg;
   logic [31:0] prdata_reg;
   mcu_port_pkg::bus_state_e state_reg;
   mcu_port_pkg::bus_state_e state_next;
   logic [15:0] addr_reg;
   logic we_reg;
   logic [7:0] wdata_reg;
   logic [7:0] rdata_reg;
   logic done_reg;

   strobe_if sif ();

   port3_strobe_unit u_strobe (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .s(sif.unit)
   );

   // --------------------------------------------------------------
   // mode decode
   // --------------------------------------------------------------
   wire pin_rst = !reset_n;
   wire single = mode_reg == mcu_port_pkg::MODE_SINGLE;
   wire nmux_page = mode_reg == mcu_port_pkg::MODE_NMUX_PAGE;
   wire nmux_full = mode_reg == mcu_port_pkg::MODE_NMUX_FULL;
   // every mode code other than 1, 5 and 7 is handled like a multiplexed mode
   wire muxed = !single && !nmux_page && !nmux_full;
   wire expanded = !single;
   wire addr_high = pin_rst && (rst_cnt_reg >= ADDR_HIGH_AT);

   // --------------------------------------------------------------
   // register bus decode
   // --------------------------------------------------------------
   wire [3:0] idx = paddr[5:2];
   wire upper_zero = (paddr[ADDR_W-1:6] == '0) && (paddr[1:0] == 2'b00);
   wire idx_port = (idx[3] == 1'b0);
   wire idx_csr = idx == mcu_port_pkg::IDX_P3_CSR;
   wire mapped = upper_zero && (idx_port || idx_csr);
   wire setup = psel && !penable;
   wire access = psel && penable;
   wire wr_ok = access && pwrite && mapped && pstrb[0];
   wire rd_ok = access && !pwrite && mapped;
   wire [1:0] pidx = port_of(idx);
   wire is_data = idx_port && idx[1];
   wire is_dir = idx_port && !idx[1];
   wire p3_hit = idx == mcu_port_pkg::IDX_P3_VAL;
   wire dir_wr = wr_ok && is_dir;
   wire data_wr = wr_ok && is_data;

   // --------------------------------------------------------------
   // read data
   // --------------------------------------------------------------
   wire [7:0] p1_rd = mix(p1_in, out_reg[0], dir_reg[0]);
   wire [7:0] p2_rd = mix({3'b000, p2_in}, out_reg[1], dir_reg[1]);
   wire [7:0] p3_live = mix(p3_in, out_reg[2], dir_reg[2]);
   wire [7:0] p3_rd = sif.held ? sif.held_data : p3_live;
   wire [7:0] p4_rd = mix(p4_in, out_reg[3], dir_reg[3]);
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      case (idx)
         mcu_port_pkg::IDX_P1_VAL: rd_byte = p1_rd;
         mcu_port_pkg::IDX_P2_VAL: rd_byte = {mode_reg, p2_rd[4:0]};
         mcu_port_pkg::IDX_P3_VAL: rd_byte = p3_rd;
         mcu_port_pkg::IDX_P4_VAL: rd_byte = p4_rd;
         mcu_port_pkg::IDX_P3_CSR: rd_byte = sif.csr_rdata;
         default: rd_byte = 8'h00;
      endcase
   end

   // --------------------------------------------------------------
   // strobe unit hookup
   // --------------------------------------------------------------
   assign sif.csr_wr = wr_ok && idx_csr;
   assign sif.csr_rd = rd_ok && idx_csr;
   assign sif.data_rd = rd_ok && p3_hit && single;
   assign sif.data_wr = wr_ok && p3_hit && single;
   assign sif.wdata = pwdata[7:0];
   assign sif.pins = p3_in;
   assign sif.strobe_in = sc1_in;
   assign sif.enable = single && reset_n;
   assign sif.pin_rst = pin_rst;

   // --------------------------------------------------------------
   // port registers and reset pin tracking
   // --------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 4; i++) begin
            dir_reg[i] <= mcu_port_pkg::DIR_RESET;
            out_reg[i] <= mcu_port_pkg::OUT_RESET;
         end
      end else if (pin_rst) begin
         for (int i = 0; i < 4; i++) begin
            dir_reg[i] <= mcu_port_pkg::DIR_RESET;
         end
      end else begin
         if (dir_wr) begin
            dir_reg[pidx] <= pwdata[7:0];
         end
         if (data_wr) begin
            out_reg[pidx] <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mode_reg <= mcu_port_pkg::MODE_RESET;
         rst_prev_reg <= 1'b1;
         rst_cnt_reg <= 2'b00;
      end else begin
         rst_prev_reg <= reset_n;
         if (reset_n) begin
            rst_cnt_reg <= 2'b00;
         end else if (rst_cnt_reg != 2'b11) begin
            rst_cnt_reg <= rst_cnt_reg + 2'b01;
         end
         if (reset_n && !rst_prev_reg) begin
            mode_reg <= p2_in[2:0];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setup) begin
         prdata_reg <= {24'h00_0000, mapped ? rd_byte : 8'h00};
      end
   end

   assign prdata = prdata_reg;
   assign pready = access;
   assign pslverr = access && !mapped;

   // --------------------------------------------------------------
   // external bus sequencer (expanded modes)
   // --------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         mcu_port_pkg::BUS_IDLE: begin
            if (bus_req && expanded && reset_n) begin
               state_next = mcu_port_pkg::BUS_ADDR;
            end
         end
         mcu_port_pkg::BUS_ADDR: state_next = mcu_port_pkg::BUS_DATA;
         mcu_port_pkg::BUS_DATA: state_next = mcu_port_pkg::BUS_IDLE;
         default: state_next = mcu_port_pkg::BUS_IDLE;
      endcase
   end

   wire take = (state_reg == mcu_port_pkg::BUS_IDLE) &&
      (state_next == mcu_port_pkg::BUS_ADDR);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= mcu_port_pkg::BUS_IDLE;
         addr_reg <= 16'h0000;
         we_reg <= 1'b0;
         wdata_reg <= 8'h00;
         rdata_reg <= 8'h00;
         done_reg <= 1'b0;
      end else begin
         state_reg <= pin_rst ? mcu_port_pkg::BUS_IDLE : state_next;
         done_reg <= (state_reg == mcu_port_pkg::BUS_DATA) && !pin_rst;
         if (take) begin
            addr_reg <= bus_addr;
            we_reg <= bus_we;
            wdata_reg <= bus_wdata;
         end
         if (state_reg == mcu_port_pkg::BUS_DATA && !we_reg) begin
            rdata_reg <= p3_in;
         end
      end
   end

   assign bus_rdata = rdata_reg;
   assign bus_done = done_reg;

   // --------------------------------------------------------------
   // pin drive
   // --------------------------------------------------------------
   wire busy = state_reg != mcu_port_pkg::BUS_IDLE;
   wire in_addr = state_reg == mcu_port_pkg::BUS_ADDR;
   wire in_data = state_reg == mcu_port_pkg::BUS_DATA;
   wire writing = busy && we_reg;
   wire page_hit = (addr_reg[15:9] == mcu_port_pkg::IO_PAGE_HIGH) &&
      addr_reg[8];
   wire [7:0] lo_addr = addr_high ? 8'hff : addr_reg[7:0];
   wire [7:0] hi_addr = addr_high ? 8'hff : addr_reg[15:8];

   assign p1_out = nmux_full ? lo_addr : out_reg[0];
   assign p1_oe = nmux_full ? 8'hff : dir_reg[0];
   assign p2_out = out_reg[1][4:0];
   // bit 1 is input or timer only, never a port output
   assign p2_oe = dir_reg[1][4:0] & ~mcu_port_pkg::P2_OUT_FORBID;

   // direction register is ignored once a bus mode is active
   assign p3_out = single ? out_reg[2] :
      ((in_addr && muxed) ? addr_reg[7:0] : wdata_reg);
   assign p3_oe = single ? dir_reg[2] :
      (((in_addr && muxed) || (in_data && we_reg)) ? 8'hff : 8'h00);

   assign p4_out = single ? out_reg[3] : (nmux_page ? lo_addr : hi_addr);
   assign p4_oe = (single || nmux_page) ? dir_reg[3] : 8'hff;

   // sc1: strobe input, address strobe, or active-low page strobe
   assign sc1_out = muxed ? in_addr : !(in_data && page_hit);
   assign sc1_oe = muxed || nmux_page;
   // sc2: output strobe, or read/write that rests high
   assign sc2_out = single ? sif.ostb_n : !writing;
   assign maskable_irq_a = sif.irq && single;
   assign mode = mode_reg;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   chk_p21_input: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !p2_oe[1])
      else $error("second-port bit 1 driven as output");
   chk_dir_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (dir_wr && pidx == 2'd0 && !nmux_full) |=> p1_oe == $past(pwdata[7:0]))
      else $error("first-port drive does not follow direction");
   chk_mode_capture: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(reset_n) |=> mode_reg == $past(p2_in[2:0]))
      else $error("mode not latched at reset release");
   chk_addr_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!reset_n [*3]) ##0 (expanded && !nmux_page) |-> p4_out == 8'hff)
      else $error("address lines not high in reset");
   chk_rw_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (take && !pin_rst) |=> (sc2_out == !$past(bus_we)) ##2 sc2_out)
      else $error("read/write level wrong around access");
   chk_bus_sequence: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (take && muxed && !pin_rst) |=> sc1_out ##1 !sc1_out ##1 bus_done)
      else $error("address strobe sequence broken");
   chk_dir_reset: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!reset_n ##1 !reset_n) |-> dir_reg[0] == mcu_port_pkg::DIR_RESET)
      else $error("first port not input in reset");
   cov_mode_change: cover property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(reset_n) ##1 !single);
   cov_page_strobe: cover property (@(posedge clk_sys) disable iff (sys_rst)
      nmux_page && in_data && page_hit);
   cov_bus_write: cover property (@(posedge clk_sys) disable iff (sys_rst)
      take && bus_we ##2 bus_done);
endmodule
`default_nettype wire

// file: core/mcu_port_pkg.sv
// constants, register map and types of the parallel port unit
//
// Overview of operation
// - direction bit 1 drives pin, 0 inputs
// - direction registers write-only, read as zero
// - data 2,3,6,7; direction 0,1,4,5
// - second-port bit 1 never drives output
// - input-configured pins stay high impedance
// - first port inputs after reset; mode 1 address
// - second port five lines, inputs after reset
// - reset release latches mode from pins 2:0
// - reset low three cycles drives address high
// - expanded: third port follows read/write
// - mode 7: third port I/O plus strobes
// - input strobe falling edge sets flag, latches
// - output strobe on read/write per select
// - input strobe edge raises maskable interrupt
// - read/write high reading, low writing, idle high
// - mode 5 page strobe for 0x0100-0x01ff
// - address strobe marks low address on port
// - latch enable holds data until port read
// - flag read-only, cleared status-then-port access
// - interrupt only with flag and enable set
package mcu_port_pkg;
   // --------------------------------------------------------------
   // register indices, byte address is four times the index
   // --------------------------------------------------------------
   localparam logic [3:0] IDX_P1_DIR = 4'h0;
   localparam logic [3:0] IDX_P2_DIR = 4'h1;
   localparam logic [3:0] IDX_P1_VAL = 4'h2;
   localparam logic [3:0] IDX_P2_VAL = 4'h3;
   localparam logic [3:0] IDX_P3_DIR = 4'h4;
   localparam logic [3:0] IDX_P4_DIR = 4'h5;
   localparam logic [3:0] IDX_P3_VAL = 4'h6;
   localparam logic [3:0] IDX_P4_VAL = 4'h7;
   localparam logic [3:0] IDX_P3_CSR = 4'hf;
   // --------------------------------------------------------------
   // strobe control/status fields
   // --------------------------------------------------------------
   localparam int CSR_LATCH_BIT = 3;
   localparam int CSR_OSS_BIT = 4;
   localparam int CSR_IEN_BIT = 6;
   localparam int CSR_FLAG_BIT = 7;
   // --------------------------------------------------------------
   // modes, reset values, timing
   // --------------------------------------------------------------
   localparam logic [2:0] MODE_SINGLE = 3'h7;
   localparam logic [2:0] MODE_NMUX_PAGE = 3'h5;
   localparam logic [2:0] MODE_NMUX_FULL = 3'h1;
   localparam logic [2:0] MODE_RESET = 3'h7;
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] OUT_RESET = 8'h00;
   localparam logic [4:0] P2_OUT_FORBID = 5'h02;
   localparam logic [6:0] IO_PAGE_HIGH = 7'h00;
   localparam int CLK_NS = 4;
   localparam int ECYC_NS = 4;
   localparam int RST_LOW_TCYC = 3;
   localparam int RST_LOW_CYCLES = (RST_LOW_TCYC * ECYC_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ADDR = 2'b01,
      BUS_DATA = 2'b10
   } bus_state_e;
endpackage

// file: core/strobe_if.sv
// handshake signals between the port core and the strobe unit
`timescale 1ns/1ps
`default_nettype none
interface strobe_if;
   logic csr_wr;
   logic csr_rd;
   logic data_rd;
   logic data_wr;
   logic [7:0] wdata;
   logic [7:0] pins;
   logic strobe_in;
   logic enable;
   logic pin_rst;
   logic [7:0] csr_rdata;
   logic [7:0] held_data;
   logic held;
   logic ostb_n;
   logic irq;
   modport core (output csr_wr, csr_rd, data_rd, data_wr, wdata, pins,
      strobe_in, enable, pin_rst, input csr_rdata, held_data, held, ostb_n,
      irq);
   modport unit (input csr_wr, csr_rd, data_rd, data_wr, wdata, pins,
      strobe_in, enable, pin_rst, output csr_rdata, held_data, held, ostb_n,
      irq);
endinterface
`default_nettype wire

// file: core/port3_strobe_unit.sv
// third-port handshake: input strobe flag, input latch, output strobe
`timescale 1ns/1ps
`default_nettype none
module port3_strobe_unit (
   input wire logic clk_sys,
   input wire logic sys_rst,
   strobe_if.unit s
);
   logic strobe_prev_reg;
   logic latch_en_reg;
   logic oss_reg;
   logic ien_reg;
   logic flag_reg;
   logic armed_reg;
   logic held_reg;
   logic [7:0] held_data_reg;
   logic ostb_n_reg;
   wire fall = s.enable && strobe_prev_reg && !s.strobe_in;
   wire port_touch = s.data_rd || s.data_wr;
   wire clear_flag = armed_reg && port_touch;
   wire ostb_fire = s.enable &&
      ((s.data_rd && !oss_reg) || (s.data_wr && oss_reg));
   wire capture = fall && latch_en_reg && (!held_reg || s.data_rd);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         strobe_prev_reg <= 1'b1;
         latch_en_reg <= 1'b0;
         oss_reg <= 1'b0;
         ien_reg <= 1'b0;
         flag_reg <= 1'b0;
         armed_reg <= 1'b0;
         held_reg <= 1'b0;
         held_data_reg <= 8'h00;
         ostb_n_reg <= 1'b1;
      end else if (s.pin_rst) begin
         strobe_prev_reg <= 1'b1;
         latch_en_reg <= 1'b0;
         oss_reg <= 1'b0;
         ien_reg <= 1'b0;
         flag_reg <= 1'b0;
         armed_reg <= 1'b0;
         held_reg <= 1'b0;
         ostb_n_reg <= 1'b1;
      end else begin
         strobe_prev_reg <= s.strobe_in;
         if (s.csr_wr) begin
            // takes effect from the next clock cycle
            latch_en_reg <= s.wdata[mcu_port_pkg::CSR_LATCH_BIT];
            oss_reg <= s.wdata[mcu_port_pkg::CSR_OSS_BIT];
            ien_reg <= s.wdata[mcu_port_pkg::CSR_IEN_BIT];
         end
         // a new edge beats a clear in the same cycle
         if (fall) begin
            flag_reg <= 1'b1;
         end else if (clear_flag) begin
            flag_reg <= 1'b0;
         end
         if (clear_flag || fall) begin
            armed_reg <= 1'b0;
         end else if (s.csr_rd && flag_reg) begin
            armed_reg <= 1'b1;
         end
         if (capture) begin
            held_reg <= 1'b1;
            held_data_reg <= s.pins;
         end else if (s.data_rd) begin
            held_reg <= 1'b0;
         end
         ostb_n_reg <= !ostb_fire;
      end
   end

   assign s.csr_rdata = {flag_reg, ien_reg, 1'b0, oss_reg, latch_en_reg,
      3'b000};
   assign s.held_data = held_data_reg;
   assign s.held = held_reg;
   assign s.ostb_n = ostb_n_reg;
   assign s.irq = flag_reg && ien_reg;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   chk_fall_sets_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (fall && !s.pin_rst) |=> flag_reg)
      else $error("strobe edge did not set flag");
   chk_ostrobe_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (s.enable && !s.pin_rst && s.data_rd && !oss_reg)
      |=> !s.ostb_n ##1 s.ostb_n)
      else $error("output strobe missing on read");
   chk_irq_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(s.irq) |-> $past(fall) || $past(s.csr_wr))
      else $error("interrupt raised without edge or enable");
   chk_flag_clear_seq: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (flag_reg && !armed_reg && !s.pin_rst) |=> flag_reg)
      else $error("flag cleared without status read");
   chk_latch_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (held_reg && !s.data_rd && !s.pin_rst) |=> held_reg &&
      $stable(held_data_reg))
      else $error("held data lost before port read");
   cov_irq_raise: cover property (@(posedge clk_sys) disable iff (sys_rst)
      fall && ien_reg ##1 s.irq);
   cov_write_strobe: cover property (@(posedge clk_sys) disable iff (sys_rst)
      s.data_wr && oss_reg ##1 !s.ostb_n);
endmodule
`default_nettype wire

// file: core/_unused_end.sv
// intentionally empty file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: tb/ext_periph.sv
// far-side handshaking device on the third port
`timescale 1ns/1ps
`default_nettype none
module ext_periph (
   input wire logic clk_sys,
   input wire logic go,
   input wire logic [7:0] val,
   output logic strobe_n,
   output logic [7:0] p1_pins,
   output logic [7:0] p3_pins
);
   logic [2:0] step;
   initial begin
      step = 3'h0;
      strobe_n = 1'b1;
      p3_pins = 8'h00;
   end
   assign p1_pins = val;
   // -----------------------------------------------------------
   // data valid around a two-cycle low strobe
   // -----------------------------------------------------------
   always @(posedge clk_sys) begin
      if (go) begin
         step <= 3'h1;
      end else if (step != 3'h0) begin
         step <= (step == 3'h4) ? 3'h0 : step + 3'h1;
      end
      strobe_n <= !(step == 3'h1 || step == 3'h2);
      // released lines toggle so a stale value cannot pass
      p3_pins <= (step != 3'h0) ? val : ~p3_pins;
   end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the parallel port unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_sys, sys_rst, psel, penable, pwrite, reset_n, pready;
   logic pslverr, sc1_in, sc1_out, sc1_oe, sc2_out, irq, go, done, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [4:0] p2_in, p2_out, p2_oe;
   logic [7:0] p1_in, p1_out, p1_oe, p3_in, p3_out, p3_oe, p4_out, p4_oe;
   logic [7:0] pval, bus_rdata, bus_wdata, ph_a, ph_d, pa, pd;
   logic [7:0] rs_oe, rs_addr;
   logic [15:0] bus_addr;
   logic [2:0] mode;
   logic bus_req, bus_we, ph_done;
   int err_total, checks, os_cnt, cyc, n;
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   mcu_parallel_port_unit dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .reset_n(reset_n), .p1_in(p1_in), .p1_out(p1_out),
      .p1_oe(p1_oe), .p2_in(p2_in), .p2_out(p2_out), .p2_oe(p2_oe),
      .p3_in(p3_in), .p3_out(p3_out), .p3_oe(p3_oe), .p4_in(p1_in),
      .p4_out(p4_out), .p4_oe(p4_oe), .sc1_in(sc1_in), .sc1_out(sc1_out),
      .sc1_oe(sc1_oe), .sc2_out(sc2_out), .maskable_irq_a(irq),
      .mode(mode), .bus_req(bus_req), .bus_addr(bus_addr), .bus_we(bus_we),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_done(done));
   ext_periph far (.clk_sys(clk_sys), .go(go), .val(pval),
      .strobe_n(sc1_in), .p1_pins(p1_in), .p3_pins(p3_in));
   // -----------------------------------------------------------
   // tasks
   // -----------------------------------------------------------
   task automatic chk(input string name, input logic [7:0] exp,
      input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [3:0] idx,
      input logic [7:0] wd);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {6'h00, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      pstrb <= 4'hf;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   // one external bus access; phases sampled before the next edge lands
   task automatic ext(input logic we, input logic [15:0] a,
      input logic [7:0] d);
      bus_req <= 1'b1;
      bus_we <= we;
      bus_addr <= a;
      bus_wdata <= d;
      pval <= d;
      go <= 1'b1;
      @(posedge clk_sys);
      bus_req <= 1'b0;
      go <= 1'b0;
      @(posedge clk_sys);
      ph_a = {5'h00, sc1_out, sc2_out, p3_oe[0]};
      pa = p3_out;
      @(posedge clk_sys);
      ph_d = {5'h00, sc1_out, sc2_out, p3_oe[0]};
      pd = p3_out;
      @(posedge clk_sys);
      ph_done = done;
   endtask
   // chip reset pin low for four edges, new mode strapped on port 2
   task automatic pin_reset(input logic [4:0] m);
      reset_n <= 1'b0;
      p2_in <= m;
      repeat (4) @(posedge clk_sys);
      rs_oe = p1_oe;
      rs_addr = p4_out;
      reset_n <= 1'b1;
      @(posedge clk_sys);
      p2_in <= 5'h00;
      @(posedge clk_sys);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // low cycles of the output strobe, plus the hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (sc2_out === 1'b0) os_cnt++;
      if (cyc == 5000) begin
         err_total++;
         print_verdict;
      end
   end
   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial begin
      {psel, penable, pwrite, go, bus_req, bus_we} = '0;
      {err_total, checks, os_cnt, cyc} = '0;
      {paddr, pwdata, pstrb, bus_addr, bus_wdata} = '0;
      sys_rst = 1'b1;
      reset_n = 1'b0;
      p2_in = 5'h07;
      pval = 8'h3c;
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      p2_in <= 5'h00;
      chk("p1_oe", 8'h00, p1_oe);
      chk("p2_oe", 8'h00, {3'h0, p2_oe});
      apb(1'b1, mcu_port_pkg::IDX_P1_DIR, 8'hf0);
      apb(1'b0, mcu_port_pkg::IDX_P1_DIR, 8'h00);
      chk("p1_dir", 8'h00, rd[7:0]);
      chk("p1_oe", 8'hf0, p1_oe);
      apb(1'b1, mcu_port_pkg::IDX_P1_VAL, 8'ha5);
      chk("p1_out", 8'ha0, p1_out & p1_oe);
      apb(1'b0, mcu_port_pkg::IDX_P1_VAL, 8'h00);
      chk("p1_val", 8'hac, rd[7:0]);
      apb(1'b0, mcu_port_pkg::IDX_P2_VAL, 8'h00);
      chk("p2_mode", 8'he0, rd[7:0] & 8'he0);
      apb(1'b1, mcu_port_pkg::IDX_P2_DIR, 8'h1f);
      chk("p2_oe", 8'h1d, {3'h0, p2_oe});
      apb(1'b0, 4'h8, 8'h00);
      chk("unmapped", 8'h01, {7'h00, err});
      apb(1'b1, mcu_port_pkg::IDX_P4_DIR, 8'hff);
      chk("p4_oe", 8'hff, p4_oe);
      apb(1'b1, mcu_port_pkg::IDX_P3_DIR, 8'h00);
      chk("p3_oe", 8'h00, p3_oe);
      apb(1'b1, mcu_port_pkg::IDX_P3_CSR, 8'h48);
      chk("irq", 8'h00, {7'h00, irq});
      pval <= 8'h5a;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chk("irq", 8'h01, {7'h00, irq});
      apb(1'b0, mcu_port_pkg::IDX_P3_CSR, 8'h00);
      chk("csr", 8'hc8, rd[7:0]);
      n = os_cnt;
      apb(1'b0, mcu_port_pkg::IDX_P3_VAL, 8'h00);
      chk("p3_val", 8'h5a, rd[7:0]);
      repeat (2) @(posedge clk_sys);
      chk("ostrobe", 8'(n + 1), 8'(os_cnt));
      chk("irq", 8'h00, {7'h00, irq});
      apb(1'b1, mcu_port_pkg::IDX_P3_VAL, 8'h77);
      repeat (2) @(posedge clk_sys);
      chk("ostrobe", 8'(n + 1), 8'(os_cnt));
      apb(1'b1, mcu_port_pkg::IDX_P3_CSR, 8'h10);
      apb(1'b1, mcu_port_pkg::IDX_P3_VAL, 8'h77);
      repeat (2) @(posedge clk_sys);
      chk("ostrobe", 8'(n + 2), 8'(os_cnt));
      apb(1'b1, mcu_port_pkg::IDX_P3_DIR, 8'hff);
      chk("p3_oe", 8'hff, p3_oe);
      pin_reset(5'h05);
      chk("p1_oe", 8'h00, rs_oe);
      chk("mode", 8'h05, {5'h00, mode});
      apb(1'b1, mcu_port_pkg::IDX_P3_DIR, 8'hff);
      chk("p3_oe", 8'h00, p3_oe);
      chk("rw_idle", 8'h01, {7'h00, sc2_out});
      ext(1'b1, 16'h0123, 8'h99);
      chk("wr_addr_phase", 8'h04, ph_a);
      chk("wr_data_phase", 8'h01, ph_d);
      chk("wr_data", 8'h99, pd);
      chk("wr_done", 8'h01, {7'h00, ph_done});
      pin_reset(5'h06);
      chk("addr_high", 8'hff, rs_addr);
      ext(1'b0, 16'h4a7e, 8'h6e);
      chk("rd_addr_phase", 8'h07, ph_a);
      chk("rd_data_phase", 8'h02, ph_d);
      chk("rd_addr_lo", 8'h7e, pa);
      chk("rd_data", 8'h6e, bus_rdata);
      pin_reset(5'h01);
      chk("addr_high", 8'hff, rs_addr);
      chk("p1_oe", 8'hff, p1_oe);
      chk("p1_addr", 8'h7e, p1_out);
      print_verdict;
   end
endmodule
`default_nettype wire
